// ---- pkg/dpio_pkg.sv ----
// constants and carrier types for the dual port pin function block
// assumes an apb slave with 22-bit byte address and 32-bit data
package dpio_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 22;
    localparam logic [19:0] SIX_DIR_IDX = 20'hee008;
    localparam logic [19:0] EIGHT_DIR_IDX = 20'hee009;
    localparam logic [19:0] SIX_DAT_IDX = 20'hfffd8;
    localparam logic [19:0] EIGHT_DAT_IDX = 20'hfffd9;
    localparam logic [ADDR_W-1:0] SIX_DIR_ADDR = {SIX_DIR_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] EIGHT_DIR_ADDR = {EIGHT_DIR_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] SIX_DAT_ADDR = {SIX_DAT_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] EIGHT_DAT_ADDR = {EIGHT_DAT_IDX, 2'h0};

    // ------------------------------------------------------------
    // reset values and fixed bits
    // ------------------------------------------------------------
    localparam logic [7:0] SIX_DIR_RST = 8'hc0;
    localparam logic [7:0] SIX_DAT_RST = 8'hc0;
    localparam logic [7:0] SIX_RSV_MASK = 8'hc0;
    localparam logic [7:0] EIGHT_DIR_RST_M12 = 8'h00;
    localparam logic [7:0] EIGHT_DIR_RST_M34 = 8'h80;
    localparam logic [7:0] EIGHT_DAT_RST = 8'h00;
    localparam logic [7:0] EIGHT_TOP_MASK = 8'h80;
    localparam logic [7:0] RD_ALL_ONES = 8'hff;
    localparam logic [23:0] RD_PAD = 24'h000000;

    // ------------------------------------------------------------
    // pin positions in the six-bit port and the top eight-bit pin
    // ------------------------------------------------------------
    localparam int SCK_BIT0 = 4;
    localparam int RXD_BIT0 = 2;
    localparam int TXD_BIT0 = 0;
    localparam int EIGHT_TOP = 7;

    // serial channel controls, one bit per channel except the shared smart_card_select
    typedef struct packed {
        logic [1:0] external_clock_enable;
        logic [1:0] internal_clock_output_enable;
        logic [1:0] sync_mode;
        logic [1:0] receiver_enable;
        logic [1:0] transmitter_enable;
        logic [1:0] sck_out;
        logic [1:0] txd_out;
        logic [1:0] txd_drive;
        logic smart_card_select;
    } dpio_sci_s;

    // timer and pattern controls for the top eight-bit pin
    typedef struct packed {
        logic cmp_b_out_sel;
        logic cmp_b_out;
        logic pulse_width_mode_ch2;
        logic io_control_b_bit2;
        logic pattern_enable_bit7;
        logic pattern_output7;
    } dpio_tmr_s;

    // serial side results
    typedef struct packed {
        logic [1:0] sck_in;
        logic [1:0] rxd_in;
    } dpio_sci_in_s;

endpackage

// ---- src/dpio_sync.sv ----
// two flip-flop synchroniser for pin levels
// assumes one clock; en freezes both stages
module dpio_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // first stage is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= RST;
            q_r <= RST;
        end else if (en) begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;

endmodule

// ---- src/dpio_top.sv ----
// six-bit and eight-bit general purpose ports with shared pin functions
// assumes apb master on pclk; serial and timer controls arrive on pclk
//
// The APB slave port was chosen for this implementation.
module dpio_top (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dpio_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // chip state pins
    input wire logic hw_standby,
    input wire logic mode_three_four,
    // peripheral controls
    input wire dpio_pkg::dpio_sci_s sci,
    input wire dpio_pkg::dpio_tmr_s tmr,
    input wire logic [1:0] interrupt_enable_reg,
    input wire logic address_bit_twenty,
    // peripheral results
    output dpio_pkg::dpio_sci_in_s sci_in,
    output logic [1:0] ext_irq_n,
    output logic timer2_capture_b,
    // six-bit port pins
    input wire logic [5:0] six_in,
    output logic [5:0] six_out,
    output logic [5:0] six_oe,
    // eight-bit port pins
    input wire logic [7:0] eight_in,
    output logic [7:0] eight_out,
    output logic [7:0] eight_oe
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] six_dir;
        logic [7:0] six_dat;
        logic [7:0] eight_dir;
        logic [7:0] eight_dat;
        logic [7:0] rdat;
        logic pready;
        logic pslverr;
        logic [5:0] six_out;
        logic [5:0] six_oe;
        logic [7:0] eight_out;
        logic [7:0] eight_oe;
        logic [1:0] sck_in;
        logic [1:0] rxd_in;
        logic [1:0] irq_n;
        logic cap_b;
    } dpio_state_s;

    localparam dpio_state_s ST_RST = '{
        six_dir: dpio_pkg::SIX_DIR_RST,
        six_dat: dpio_pkg::SIX_DAT_RST,
        eight_dir: dpio_pkg::EIGHT_DIR_RST_M12,
        eight_dat: dpio_pkg::EIGHT_DAT_RST,
        rdat: 8'h00,
        pready: 1'b0,
        pslverr: 1'b0,
        six_out: 6'h00,
        six_oe: 6'h00,
        eight_out: 8'h00,
        eight_oe: 8'h00,
        sck_in: 2'h3,
        rxd_in: 2'h3,
        irq_n: 2'h3,
        cap_b: 1'b0
    };

    dpio_state_s st_r;
    dpio_state_s st_nxt;

    // synchronised pin levels
    logic [5:0] six_s;
    logic [7:0] eight_s;
    logic hws_s;
    logic m34_s;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    dpio_sync #(.W(16), .RST(16'h0000)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .en(pclk_en),
        .d({hw_standby, mode_three_four, six_in, eight_in}),
        .q({hws_s, m34_s, six_s, eight_s})
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    localparam int SCK_BIT0 = dpio_pkg::SCK_BIT0;
    localparam int RXD_BIT0 = dpio_pkg::RXD_BIT0;
    localparam int TXD_BIT0 = dpio_pkg::TXD_BIT0;
    localparam int EIGHT_TOP = dpio_pkg::EIGHT_TOP;

    logic [7:0] eight_eff_dir;
    logic rd_setup;
    logic wr_take;

    // top direction bit is forced in the address modes
    assign eight_eff_dir = st_r.eight_dir | (m34_s ? dpio_pkg::EIGHT_TOP_MASK : 8'h00);
    assign rd_setup = psel && !penable;
    assign wr_take = psel && penable && st_r.pready && pwrite && pstrb[0];

    always_comb begin
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        // setup cycle: decode and capture read data
        if (rd_setup) begin
            st_nxt.pready = 1'b1;
            st_nxt.rdat = 8'h00;
            unique case (paddr)
                dpio_pkg::SIX_DIR_ADDR, dpio_pkg::EIGHT_DIR_ADDR: begin
                    st_nxt.rdat = dpio_pkg::RD_ALL_ONES;
                end
                dpio_pkg::SIX_DAT_ADDR: begin
                    st_nxt.rdat = (st_r.six_dat & st_r.six_dir) | ({2'h0, six_s} & ~st_r.six_dir);
                end
                dpio_pkg::EIGHT_DAT_ADDR: begin
                    st_nxt.rdat = (st_r.eight_dat & eight_eff_dir) | (eight_s & ~eight_eff_dir);
                end
                default: begin
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end
        // access cycle: writes land here
        if (wr_take) begin
            unique case (paddr)
                dpio_pkg::SIX_DIR_ADDR: begin
                    st_nxt.six_dir = pwdata[7:0] | dpio_pkg::SIX_RSV_MASK;
                end
                dpio_pkg::SIX_DAT_ADDR: begin
                    st_nxt.six_dat = pwdata[7:0] | dpio_pkg::SIX_RSV_MASK;
                end
                dpio_pkg::EIGHT_DIR_ADDR: begin
                    st_nxt.eight_dir = pwdata[7:0] | (m34_s ? dpio_pkg::EIGHT_TOP_MASK : 8'h00);
                end
                dpio_pkg::EIGHT_DAT_ADDR: begin
                    st_nxt.eight_dat = pwdata[7:0];
                end
                default: begin
                    st_nxt.eight_dat = st_r.eight_dat;
                end
            endcase
        end
        // hardware standby reloads the data and direction registers
        if (hws_s) begin
            st_nxt.six_dir = dpio_pkg::SIX_DIR_RST;
            st_nxt.six_dat = dpio_pkg::SIX_DAT_RST;
            st_nxt.eight_dir = m34_s ? dpio_pkg::EIGHT_DIR_RST_M34 : dpio_pkg::EIGHT_DIR_RST_M12;
            st_nxt.eight_dat = dpio_pkg::EIGHT_DAT_RST;
        end
        // general pins follow data and direction, standby or not
        st_nxt.six_out = st_r.six_dat[5:0];
        st_nxt.six_oe = st_r.six_dir[5:0];
        st_nxt.eight_out = st_r.eight_dat;
        st_nxt.eight_oe = eight_eff_dir;
        // per serial channel pin selection
        for (int c = 0; c < 2; c++) begin
            st_nxt.sck_in[c] = 1'b1;
            st_nxt.rxd_in[c] = 1'b1;
            if (sci.external_clock_enable[c]) begin
                st_nxt.six_oe[SCK_BIT0 + c] = 1'b0;
                st_nxt.sck_in[c] = six_s[SCK_BIT0 + c];
            end else if (sci.sync_mode[c] || sci.internal_clock_output_enable[c]) begin
                st_nxt.six_oe[SCK_BIT0 + c] = 1'b1;
                st_nxt.six_out[SCK_BIT0 + c] = sci.sck_out[c];
            end
            if (sci.smart_card_select || sci.receiver_enable[c]) begin
                st_nxt.six_oe[RXD_BIT0 + c] = 1'b0;
                st_nxt.rxd_in[c] = six_s[RXD_BIT0 + c];
            end
            if (sci.transmitter_enable[c] || sci.smart_card_select) begin
                st_nxt.six_out[TXD_BIT0 + c] = sci.txd_out[c];
                st_nxt.six_oe[TXD_BIT0 + c] = sci.smart_card_select ? sci.txd_drive[c] : 1'b1;
            end
            // interrupt sees the pin whatever its direction
            st_nxt.irq_n[c] = interrupt_enable_reg[c] ? six_s[SCK_BIT0 + c] : 1'b1;
        end
        // top pin of the eight-bit port
        if (m34_s) begin
            st_nxt.eight_out[EIGHT_TOP] = address_bit_twenty;
            st_nxt.eight_oe[EIGHT_TOP] = 1'b1;
        end else if (tmr.cmp_b_out_sel) begin
            st_nxt.eight_out[EIGHT_TOP] = tmr.cmp_b_out;
            st_nxt.eight_oe[EIGHT_TOP] = 1'b1;
        end else if (st_r.eight_dir[EIGHT_TOP] && tmr.pattern_enable_bit7) begin
            st_nxt.eight_out[EIGHT_TOP] = tmr.pattern_output7;
        end
        // capture input from the top pin
        st_nxt.cap_b = tmr.io_control_b_bit2 && !tmr.pulse_width_mode_ch2 && eight_s[EIGHT_TOP];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RST;
        end else if (pclk_en) begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign prdata = {dpio_pkg::RD_PAD, st_r.rdat};
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign six_out = st_r.six_out;
    assign six_oe = st_r.six_oe;
    assign eight_out = st_r.eight_out;
    assign eight_oe = st_r.eight_oe;
    assign sci_in.sck_in = st_r.sck_in;
    assign sci_in.rxd_in = st_r.rxd_in;
    assign ext_irq_n = st_r.irq_n;
    assign timer2_capture_b = st_r.cap_b;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_dir_read_ones:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && rd_setup && (paddr == dpio_pkg::SIX_DIR_ADDR || paddr == dpio_pkg::EIGHT_DIR_ADDR))
        |=> (prdata == 32'h000000ff) && pready)
    else $error("direction read not all ones");

    a_six_rsv_ones:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && rd_setup && paddr == dpio_pkg::SIX_DAT_ADDR) |=> (prdata[7:6] == 2'h3))
    else $error("reserved six-bit data bits not one");

    a_dir_to_pin:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && wr_take && paddr == dpio_pkg::EIGHT_DIR_ADDR && !hws_s) ##1 pclk_en
        |=> (eight_oe[6:0] == $past(pwdata[6:0], 2)))
    else $error("direction write did not reach pin enable");

    a_hws_six_load:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && hws_s) |=> (st_r.six_dir == 8'hc0) && (st_r.six_dat == 8'hc0))
    else $error("six-bit port not reloaded in hardware standby");

    a_hws_eight_load:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && hws_s) |=> (st_r.eight_dir == ($past(m34_s) ? 8'h80 : 8'h00)) && (st_r.eight_dat == 8'h00))
    else $error("eight-bit port not reloaded in hardware standby");

    a_addr_twenty:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && m34_s) |=> eight_oe[7] && (eight_out[7] == $past(address_bit_twenty)))
    else $error("top pin not address output");

    a_sck_input:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && sci.external_clock_enable[1]) |=> !six_oe[5] && (sci_in.sck_in[1] == $past(six_s[5])))
    else $error("external clock pin not an input");

    a_irq_follow:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && interrupt_enable_reg[0]) |=> (ext_irq_n[0] == $past(six_s[4])))
    else $error("interrupt does not follow pin");

    a_rxd_input:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && (sci.smart_card_select || sci.receiver_enable[0])) |=> !six_oe[2])
    else $error("receive pin driven");

    a_txd_smart:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && sci.smart_card_select)
        |=> (six_oe[0] == $past(sci.txd_drive[0])) && (six_out[0] == $past(sci.txd_out[0])))
    else $error("smart card transmit pin wrong");

    a_pattern_out:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && !m34_s && !tmr.cmp_b_out_sel && st_r.eight_dir[7] && tmr.pattern_enable_bit7)
        |=> eight_oe[7] && (eight_out[7] == $past(tmr.pattern_output7)))
    else $error("pattern output not on top pin");

    a_capture_b:
    assert property (@(posedge pclk) disable iff (!presetn)
        (pclk_en && tmr.pulse_width_mode_ch2) |=> !timer2_capture_b)
    else $error("capture active in pulse width mode");

endmodule

// ---- tb/dpio_pins.sv ----
// board-side model of the six-bit and eight-bit port pins
// assumes the bench sets the level that the board drives on undriven pins
module dpio_pins (
    // pin drivers of the port block
    input wire logic [5:0] six_out,
    input wire logic [5:0] six_oe,
    input wire logic [7:0] eight_out,
    input wire logic [7:0] eight_oe,
    // board levels commanded by the bench
    input wire logic [5:0] six_ext,
    input wire logic [7:0] eight_ext,
    // resolved pin levels
    output logic [5:0] six_in,
    output logic [7:0] eight_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // a driven pin shows the block's level, else the board's
    assign six_in = (six_oe & six_out) | (~six_oe & six_ext);
    assign eight_in = (eight_oe & eight_out) | (~eight_oe & eight_ext);
endmodule

// ---- tb/dpio_top_bench.sv ----
// self-checking bench for the dual port pin block
// assumes apb slave answers with pready; one 250 MHz clock
module dpio_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pclk_en = 1;
    logic [21:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, hw_standby = 0, mode_three_four = 0, address_bit_twenty = 0;
    dpio_pkg::dpio_sci_s sci = '0;
    dpio_pkg::dpio_tmr_s tmr = '0;
    dpio_pkg::dpio_sci_in_s sci_in;
    logic [1:0] interrupt_enable_reg = '0, ext_irq_n;
    logic timer2_capture_b;
    logic [5:0] six_in, six_out, six_oe, six_ext = 6'h2a;
    logic [7:0] eight_in, eight_out, eight_oe, eight_ext = 8'h5c;
    int n_mismatch = 0, checks_done = 0, cycles = 0;

    // clock and timeout
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 5000) begin
            n_mismatch++;
            stop_test();
        end
    end

    dpio_top u_dut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_standby(hw_standby), .mode_three_four(mode_three_four), .sci(sci), .tmr(tmr),
        .interrupt_enable_reg(interrupt_enable_reg), .address_bit_twenty(address_bit_twenty), .sci_in(sci_in),
        .ext_irq_n(ext_irq_n), .timer2_capture_b(timer2_capture_b), .six_in(six_in), .six_out(six_out),
        .six_oe(six_oe), .eight_in(eight_in), .eight_out(eight_out), .eight_oe(eight_oe));

    dpio_pins u_pins (.six_out(six_out), .six_oe(six_oe), .eight_out(eight_out), .eight_oe(eight_oe),
        .six_ext(six_ext), .eight_ext(eight_ext), .six_in(six_in), .eight_in(eight_in));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // compare one value against its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t value %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [21:0] a, input logic [7:0] d, output logic [31:0] rd,
        output logic err);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [21:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        apb(1, a, d, rd, err);
    endtask

    task automatic rd_is(input logic [21:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        logic err;
        apb(0, a, 8'h00, rd, err);
        check(rd, {24'h000000, exp});
    endtask

    // a control change reaches a pin-derived output after four edges; read at the fifth
    task automatic settle();
        repeat (5) @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_reset_state();
        rd_is(dpio_pkg::SIX_DIR_ADDR, 8'hff);
        rd_is(dpio_pkg::EIGHT_DIR_ADDR, 8'hff);
        rd_is(dpio_pkg::SIX_DAT_ADDR, 8'hea);
        rd_is(dpio_pkg::EIGHT_DAT_ADDR, 8'h5c);
        check(six_oe, 6'h00);
        check(eight_oe, 8'h00);
    endtask

    task automatic s_gpio();
        wr(dpio_pkg::SIX_DIR_ADDR, 8'hff);
        wr(dpio_pkg::SIX_DAT_ADDR, 8'h15);
        settle();
        check(six_oe, 6'h3f);
        check(six_out, 6'h15);
        rd_is(dpio_pkg::SIX_DAT_ADDR, 8'hd5);
        rd_is(dpio_pkg::SIX_DIR_ADDR, 8'hff);
        wr(dpio_pkg::EIGHT_DIR_ADDR, 8'h0f);
        wr(dpio_pkg::EIGHT_DAT_ADDR, 8'ha5);
        settle();
        check(eight_oe, 8'h0f);
        check(eight_out[3:0], 4'h5);
        rd_is(dpio_pkg::EIGHT_DAT_ADDR, 8'h55);
    endtask

    task automatic s_serial();
        sci.external_clock_enable <= 2'b01;
        sci.sync_mode <= 2'b10;
        sci.sck_out <= 2'b10;
        sci.receiver_enable <= 2'b01;
        sci.transmitter_enable <= 2'b10;
        sci.txd_out <= 2'b10;
        settle();
        check(six_oe, 6'h2b);
        check({six_out[5], six_out[1]}, 2'b11);
        check(sci_in.sck_in, 2'b10);
        check(sci_in.rxd_in, 2'b10);
        sci.smart_card_select <= 1;
        sci.txd_drive <= 2'b01;
        settle();
        check(six_oe[3:0], 4'h1);
        check(sci_in.rxd_in, 2'b10);
        sci <= '0;
    endtask

    task automatic s_irq();
        interrupt_enable_reg <= 2'b11;
        settle();
        check(ext_irq_n, 2'b01);
        wr(dpio_pkg::SIX_DAT_ADDR, 8'h20);
        settle();
        check(ext_irq_n, 2'b10);
        interrupt_enable_reg <= 2'b00;
        settle();
        check(ext_irq_n, 2'b11);
    endtask

    task automatic s_timer();
        tmr.io_control_b_bit2 <= 1;
        settle();
        check(timer2_capture_b, 1'b0);
        eight_ext <= 8'hdc;
        settle();
        check(timer2_capture_b, 1'b1);
        tmr.pulse_width_mode_ch2 <= 1;
        settle();
        check(timer2_capture_b, 1'b0);
        tmr.cmp_b_out_sel <= 1;
        tmr.cmp_b_out <= 1;
        settle();
        check({eight_oe[7], eight_out[7]}, 2'b11);
        tmr <= '0;
        wr(dpio_pkg::EIGHT_DIR_ADDR, 8'h8f);
        tmr.pattern_enable_bit7 <= 1;
        settle();
        check({eight_oe[7], eight_out[7]}, 2'b10);
        tmr.pattern_enable_bit7 <= 0;
        settle();
        check({eight_oe[7], eight_out[7]}, 2'b11);
    endtask

    task automatic s_standby_mode34();
        mode_three_four <= 1;
        hw_standby <= 1;
        repeat (4) @(posedge pclk);
        hw_standby <= 0;
        settle();
        check(six_oe, 6'h00);
        check(eight_oe, 8'h80);
        check(eight_out[7], 1'b0);
        address_bit_twenty <= 1;
        wr(dpio_pkg::SIX_DIR_ADDR, 8'h3f);
        wr(dpio_pkg::EIGHT_DIR_ADDR, 8'h00);
        settle();
        check({eight_oe[7], eight_out[7]}, 2'b11);
        rd_is(dpio_pkg::SIX_DAT_ADDR, 8'hc0);
        rd_is(dpio_pkg::EIGHT_DAT_ADDR, 8'h5c);
    endtask

    // clock enable low freezes every output; state moves on once it returns
    task automatic s_freeze();
        pclk_en <= 0;
        interrupt_enable_reg <= 2'b11;
        settle();
        check(ext_irq_n, 2'b11);
        check(eight_oe, 8'h80);
        pclk_en <= 1;
        settle();
        check(ext_irq_n, 2'b00);
        interrupt_enable_reg <= 2'b00;
    endtask

    task automatic s_unmapped();
        logic [31:0] rd;
        logic err;
        apb(0, 22'h000010, 8'h00, rd, err);
        check(err, 1'b1);
        apb(1, 22'h000014, 8'hff, rd, err);
        check(err, 1'b1);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        settle();
        s_reset_state();
        s_gpio();
        s_serial();
        s_irq();
        s_timer();
        s_standby_mode34();
        s_freeze();
        s_unmapped();
        stop_test();
    end
endmodule
